// *** tlalrm_params.svh ***
// Register offsets, field positions, reset values and widths of the limit alarm
`ifndef TLALRM_PARAMS_SVH
`define TLALRM_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define TLALRM_OFS_CTRL      8'h00
`define TLALRM_OFS_HIGH      8'h04
`define TLALRM_OFS_LOW       8'h08
`define TLALRM_OFS_HYST      8'h0C
`define TLALRM_OFS_CRIT      8'h10
`define TLALRM_OFS_TEMP      8'h14
`define TLALRM_OFS_STATE     8'h18
`define TLALRM_OFS_IRQ_STAT  8'h1C
`define TLALRM_OFS_IRQ_CLR   8'h20
`define TLALRM_OFS_IRQ_EN    8'h24

// ****************************************
// Field positions and widths
// ****************************************
`define TLALRM_TEMP_W        16
`define TLALRM_HYST_W        4
`define TLALRM_CTRL_MODE     0
`define TLALRM_CTRL_SHDN     1
`define TLALRM_IRQ_W         3
`define TLALRM_IRQ_CONV      0
`define TLALRM_IRQ_ALARM     1
`define TLALRM_IRQ_CRIT      2

// ****************************************
// Reset values
// ****************************************
`define TLALRM_RST_CTRL      2'h0
`define TLALRM_RST_HIGH      16'h2000
`define TLALRM_RST_LOW       16'h0280
`define TLALRM_RST_HYST      4'h5
`define TLALRM_RST_CRIT      16'h4980

`endif

// *** tlalrm_pkg.sv ***
// Types shared by the temperature limit alarm
package tlalrm_pkg;

  // Alarm behaviour; interrupt is the power-up choice
  typedef enum logic {
    TLALRM_MODE_INTERRUPT,
    TLALRM_MODE_COMPARATOR
  } tlalrm_mode_type;

  // One conversion result handed in by the converter
  typedef struct packed {
    logic        valid;
    logic [15:0] temp;
  } tlalrm_conv_type;

  // AHB-Lite slave request signals
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } tlalrm_ahb_req_type;

endpackage : tlalrm_pkg

// *** tlalrm_core.sv ***
// Temperature limit alarm with AHB-Lite register slave
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "tlalrm_params.svh"

module tlalrm_core (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         clk_en,
  input  wire tlalrm_pkg::tlalrm_ahb_req_type ahb_req,
  input  wire logic [31:0]                  hwdata,
  output logic [31:0]                       hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  input  wire tlalrm_pkg::tlalrm_conv_type  conv,
  output logic                              alarm_out,
  output logic                              critical_alarm_out,
  output logic                              shutdown,
  output logic                              irq
);
  import tlalrm_pkg::*;

  // ****************************************
  // Functions
  // ****************************************
  // Signed compare of two temperature codes
  function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
    sgt = $signed(a) > $signed(b);
  endfunction : sgt

  // Apply hysteresis in whole-degree steps of the 1/128 degree code
  function automatic logic [15:0] hyst_code(input logic [3:0] h);
    hyst_code = {5'h00, h, 7'h00};
  endfunction : hyst_code

  // ****************************************
  // Bus address phase capture
  // ****************************************
  logic        ph_valid_reg;
  logic        ph_write_reg;
  logic [7:0]  ph_addr_reg;
  wire         addr_take = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];

  // Latch address phase for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg  <= 8'h00;
    end else if (clk_en) begin
      ph_valid_reg <= addr_take;
      ph_write_reg <= ahb_req.hwrite;
      ph_addr_reg  <= ahb_req.haddr[7:0];
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************
  // Write and read decode
  // ****************************************
  wire wr_en     = ph_valid_reg & ph_write_reg & clk_en;
  wire rd_take   = addr_take & ~ahb_req.hwrite & clk_en;
  wire wr_ctrl   = wr_en & (ph_addr_reg == `TLALRM_OFS_CTRL);
  wire wr_high   = wr_en & (ph_addr_reg == `TLALRM_OFS_HIGH);
  wire wr_low    = wr_en & (ph_addr_reg == `TLALRM_OFS_LOW);
  wire wr_hyst   = wr_en & (ph_addr_reg == `TLALRM_OFS_HYST);
  wire wr_crit   = wr_en & (ph_addr_reg == `TLALRM_OFS_CRIT);
  wire wr_iclr   = wr_en & (ph_addr_reg == `TLALRM_OFS_IRQ_CLR);
  wire wr_ien    = wr_en & (ph_addr_reg == `TLALRM_OFS_IRQ_EN);

  // ****************************************
  // Configuration registers
  // ****************************************
  tlalrm_mode_type mode_reg;
  logic        shdn_reg;
  logic [15:0] high_reg;
  logic [15:0] low_reg;
  logic [3:0]  hyst_reg;
  logic [15:0] crit_reg;
  logic [2:0]  ien_reg;

  // Software-written settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= TLALRM_MODE_INTERRUPT;
      shdn_reg <= 1'b0;
      high_reg <= `TLALRM_RST_HIGH;
      low_reg  <= `TLALRM_RST_LOW;
      hyst_reg <= `TLALRM_RST_HYST;
      crit_reg <= `TLALRM_RST_CRIT;
      ien_reg  <= 3'h0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        mode_reg <= hwdata[`TLALRM_CTRL_MODE] ? TLALRM_MODE_COMPARATOR
                                               : TLALRM_MODE_INTERRUPT;
        shdn_reg <= hwdata[`TLALRM_CTRL_SHDN];
      end
      if (wr_high) high_reg <= hwdata[15:0];
      if (wr_low)  low_reg  <= hwdata[15:0];
      if (wr_hyst) hyst_reg <= hwdata[3:0];
      if (wr_crit) crit_reg <= hwdata[15:0];
      if (wr_ien)  ien_reg  <= hwdata[2:0];
    end
  end

  assign shutdown = shdn_reg;

  // ****************************************
  // Shutdown control decode
  // ****************************************
  // A shutdown write blocks a conversion landing in the same cycle,
  // so that entering shutdown never moves a comparator output
  wire         shdn_set  = wr_ctrl & hwdata[`TLALRM_CTRL_SHDN];
  // Of shutdown writes, only the 0 to 1 step of the bit clears a latched alarm
  wire         shdn_rise = shdn_set & ~shdn_reg;

  // ****************************************
  // Conversion sampling
  // ****************************************
  logic [15:0] temp_reg;
  // One result is taken per conversion pulse, never while shut down
  wire         conv_take = conv.valid & ~shdn_reg & ~shdn_set & clk_en;

  // Keep the newest result for software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_reg <= 16'h0000;
    end else if (conv_take) begin
      temp_reg <= conv.temp;
    end
  end

  // ****************************************
  // Limit comparisons
  // ****************************************
  // Release thresholds, all derived from the one hysteresis step
  wire [15:0]  hyst_step = hyst_code(hyst_reg);
  wire [15:0]  high_rel  = high_reg - hyst_step;
  wire [15:0]  low_rel   = low_reg + hyst_step;
  wire [15:0]  crit_lim  = crit_reg - hyst_step;

  // Comparisons against the arriving result, all signed
  wire         over_high = sgt(conv.temp, high_reg);
  wire         under_low = sgt(low_reg, conv.temp);
  wire         beyond    = over_high | under_low;
  wire         below_rel = sgt(high_rel, conv.temp);
  wire         above_rel = sgt(conv.temp, low_rel);
  wire         in_band   = below_rel & above_rel;
  wire         over_crit = sgt(conv.temp, crit_reg);
  wire         crit_rel  = sgt(crit_lim, conv.temp);

  // ****************************************
  // Alarm state
  // ****************************************
  logic alarm_reg;
  logic alarm_next;
  logic armed_reg;
  logic armed_next;
  logic crit_alarm_reg;
  logic crit_next;

  // Comparator: set beyond a limit, cleared only once back inside both bands
  wire cmp_alarm = beyond | (alarm_reg & ~in_band);
  wire cmp_crit  = over_crit | (crit_alarm_reg & ~crit_rel);

  // Interrupt: an excursion sets the alarm latch only while it is re-armed; the critical latch sets without re-arming
  wire int_set    = conv_take & beyond & armed_reg;
  wire int_crit   = conv_take & over_crit;
  // Any read or the start of shutdown drops the latched outputs
  wire int_rd_clr = rd_take;
  wire int_sd_clr = shdn_rise;
  wire int_clr    = int_rd_clr | int_sd_clr;

  // Next alarm state per mode; a clear wins over a same-cycle set
  always_comb begin
    alarm_next = alarm_reg;
    armed_next = armed_reg;
    crit_next  = crit_alarm_reg;
    unique case (mode_reg)
      TLALRM_MODE_COMPARATOR: begin
        // Comparator outputs ignore reads; shutdown only freezes them by blocking results
        armed_next = 1'b1;
        if (conv_take) begin
          alarm_next = cmp_alarm;
          crit_next  = cmp_crit;
        end
      end
      TLALRM_MODE_INTERRUPT: begin
        // An in-range result re-arms, a result beyond a limit disarms
        if (conv_take) begin
          armed_next = ~beyond;
        end
        if (int_set) begin
          alarm_next = 1'b1;
        end
        if (int_crit) begin
          crit_next = 1'b1;
        end
        if (int_clr) begin
          alarm_next = 1'b0;
          crit_next  = 1'b0;
        end
        if (int_sd_clr) begin
          armed_next = 1'b1;
        end
      end
    endcase
  end

  // Alarm flip-flops; the latch starts armed so the first excursion counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_reg      <= 1'b0;
      armed_reg      <= 1'b1;
      crit_alarm_reg <= 1'b0;
    end else if (clk_en) begin
      alarm_reg      <= alarm_next;
      armed_reg      <= armed_next;
      crit_alarm_reg <= crit_next;
    end
  end

  // Alarm outputs come straight from flip-flops
  assign alarm_out          = alarm_reg;
  assign critical_alarm_out = crit_alarm_reg;

  // ****************************************
  // Interrupt status
  // ****************************************
  logic [`TLALRM_IRQ_W-1:0] istat_reg;
  wire  [`TLALRM_IRQ_W-1:0] ievt;
  wire  [`TLALRM_IRQ_W-1:0] iclr;

  // Event sources: every result, and rising edges of both alarms
  assign ievt[`TLALRM_IRQ_CONV]  = conv_take;
  assign ievt[`TLALRM_IRQ_ALARM] = alarm_next & ~alarm_reg;
  assign ievt[`TLALRM_IRQ_CRIT]  = crit_next & ~crit_alarm_reg;
  // Write ones to clear; the clear register itself reads as zero
  assign iclr = wr_iclr ? hwdata[`TLALRM_IRQ_W-1:0] : 3'h0;

  // Set wins over clear, so an event in the clear cycle is never lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_reg <= 3'h0;
    end else if (clk_en) begin
      istat_reg <= (istat_reg & ~iclr) | ievt;
    end
  end

  // Level interrupt while any enabled status bit is set
  assign irq = |(istat_reg & ien_reg);

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] rdata_reg;
  wire  [7:0]  ra = ahb_req.haddr[7:0];
  wire         mode_bit = (mode_reg == TLALRM_MODE_COMPARATOR);
  // Unmapped offsets and the clear register read as zero
  wire  [31:0] rmux =
    (ra == `TLALRM_OFS_CTRL)     ? {30'h0, shdn_reg, mode_bit} :
    (ra == `TLALRM_OFS_HIGH)     ? {16'h0, high_reg} :
    (ra == `TLALRM_OFS_LOW)      ? {16'h0, low_reg} :
    (ra == `TLALRM_OFS_HYST)     ? {28'h0, hyst_reg} :
    (ra == `TLALRM_OFS_CRIT)     ? {16'h0, crit_reg} :
    (ra == `TLALRM_OFS_TEMP)     ? {16'h0, temp_reg} :
    (ra == `TLALRM_OFS_STATE)    ? {29'h0, armed_reg, crit_alarm_reg, alarm_reg} :
    (ra == `TLALRM_OFS_IRQ_STAT) ? {29'h0, istat_reg} :
    (ra == `TLALRM_OFS_IRQ_EN)   ? {29'h0, ien_reg} : 32'h0;

  // Read data is loaded when the address phase is taken, so it stands
  // through the data phase with no wait state and until the next read;
  // the state word shows the alarm level from before this read clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0;
    end else if (rd_take) begin
      rdata_reg <= rmux;
    end
  end

  // Read data leaves through a register
  assign hrdata = rdata_reg;

endmodule : tlalrm_core
`default_nettype wire

// *** tlalrm_checker.sv ***
// Port assertions of the temperature limit alarm
`timescale 1ns/100ps
`default_nettype none
module tlalrm_checker (
  input wire logic                           hclk,
  input wire logic                           hresetn,
  input wire logic                           clk_en,
  input wire tlalrm_pkg::tlalrm_ahb_req_type ahb_req,
  input wire logic [31:0]                    hwdata,
  input wire tlalrm_pkg::tlalrm_conv_type    conv,
  input wire logic                           alarm_out,
  input wire logic                           shutdown,
  input wire logic                           irq
);
  import tlalrm_pkg::*;
  logic wa_reg;
  logic md_reg;
  // Taken address phases
  wire tk = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1] & clk_en;
  wire rd = tk & !ahb_req.hwrite;
  // Shadow of the mode bit, 1 = comparator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wa_reg <= 1'b0;
      md_reg <= 1'b0;
    end else if (clk_en) begin
      wa_reg <= tk & ahb_req.hwrite & (ahb_req.haddr == 32'h0);
      if (wa_reg) md_reg <= hwdata[0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd;
    rd && !md_reg;
  endsequence
  property p_rst; $rose(hresetn) |-> !alarm_out && !shutdown && !irq; endproperty
  property p_cause; $rose(alarm_out) |-> $past(conv.valid); endproperty
  property p_rdclr; s_rd |=> !alarm_out; endproperty
  property p_idle; !md_reg && !alarm_out && !conv.valid |=> !alarm_out; endproperty
  property p_sdint; !md_reg && $rose(shutdown) |-> !alarm_out; endproperty
  property p_sdcmp; md_reg && $rose(shutdown) |-> $stable(alarm_out); endproperty
  property p_cmp; md_reg && $changed(alarm_out) |-> $past(conv.valid); endproperty
  property p_frz; shutdown && $past(shutdown) |-> !$rose(alarm_out); endproperty
  a_rst: assert property (p_rst) else $error("output set after reset");
  a_cause: assert property (p_cause) else $error("alarm rose with no result");
  a_rdclr: assert property (p_rdclr) else $error("read left alarm set");
  a_idle: assert property (p_idle) else $error("alarm rose with no result");
  a_sdint: assert property (p_sdint) else $error("shutdown left alarm set");
  a_sdcmp: assert property (p_sdcmp) else $error("shutdown moved alarm");
  a_cmp: assert property (p_cmp) else $error("alarm moved with no result");
  a_frz: assert property (p_frz) else $error("alarm rose in shutdown");
endmodule : tlalrm_checker
`default_nettype wire

// *** tlalrm_host.sv ***
// AHB-Lite master model that reads and writes the alarm registers
`timescale 1ns/100ps
`default_nettype none
module tlalrm_host (
  input wire logic                          hclk,
  input wire logic                          hready,
  input wire logic [31:0]                   hrdata,
  output var tlalrm_pkg::tlalrm_ahb_req_type rq,
  output var logic [31:0]                   hwdata
);
  import tlalrm_pkg::*;
  initial begin
    rq = '0;
    hwdata = 32'h0;
  end
  // One single word transfer; no latency is assumed
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    rq <= '{1'b1, {24'h0, a}, 2'h2, w, 3'h2, 1'b0};
    do @(posedge hclk); while (hready !== 1'b1);
    rq.htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~d; // Released data shows no stale word
  endtask : xfer
endmodule : tlalrm_host
`default_nettype wire

// *** temperature_limit_alarm_test.sv ***
// Self-checking bench of the temperature limit alarm
`timescale 1ns/100ps
`default_nettype none
module temperature_limit_alarm_test;
  import tlalrm_pkg::*;
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               clk_en = 1'b1;
  tlalrm_ahb_req_type rq;
  tlalrm_ahb_req_type ahb;
  tlalrm_conv_type    conv = '0;
  logic [31:0]        hwdata;
  logic [31:0]        hrdata;
  logic [31:0]        q;
  logic               rdy;
  logic               alarm_out;
  logic               irq;
  logic               crit_out;
  logic               sd;
  logic               resp;
  int                 err_total = 0;
  int                 comparisons = 0;
  assign ahb = {rq[39:1], rdy};
  always #50 hclk = ~hclk;
  tlalrm_core i_dut (.hclk, .hresetn, .clk_en, .ahb_req(ahb), .hwdata, .hrdata,
    .hreadyout(rdy), .hresp(resp), .conv, .alarm_out, .critical_alarm_out(crit_out),
    .shutdown(sd), .irq);
  tlalrm_host i_host (.hclk, .hready(rdy), .hrdata, .rq, .hwdata);
  // Word compare
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Alarm level once the edge has landed
  task cka(input logic e);
    #1;
    chk({31'h0, alarm_out}, {31'h0, e});
  endtask : cka
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask : wr
  task rc(input logic [7:0] a, input logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rc
  // One conversion result, then the alarm level
  task tc(input logic [15:0] t, input logic e);
    @(posedge hclk);
    conv <= '{1'b1, t};
    @(posedge hclk);
    conv <= '{1'b0, ~t};
    cka(e);
  endtask : tc
  task stop_test;
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // Hang guard, far beyond the run length
  initial begin
    #200000;
    err_total++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rc(8'h00, 32'h0);
    chk({31'h0, resp}, 32'h0);
    rc(8'h0C, 32'h5);
    rc(8'h40, 32'h0);
    wr(8'h24, 32'h2);
    tc(16'h2100, 1'b1);
    #1 chk({31'h0, irq}, 32'h1);
    chk({31'h0, crit_out}, 32'h0);
    rc(8'h14, 32'h2100);
    cka(1'b0);
    rc(8'h1C, 32'h3);
    wr(8'h20, 32'h7);
    #1 chk({31'h0, irq}, 32'h0);
    tc(16'h2100, 1'b0);
    tc(16'h1000, 1'b0);
    tc(16'h0100, 1'b1);
    wr(8'h24, 32'h0);
    #1 chk({31'h0, irq}, 32'h0);
    wr(8'h00, 32'h2);
    cka(1'b0);
    chk({31'h0, sd}, 32'h1);
    tc(16'h3000, 1'b0);
    wr(8'h00, 32'h1);
    tc(16'h2100, 1'b1);
    tc(16'h1F00, 1'b1);
    rc(8'h00, 32'h1);
    cka(1'b1);
    tc(16'h1D00, 1'b0);
    tc(16'h0200, 1'b1);
    tc(16'h0480, 1'b1);
    tc(16'h0600, 1'b0);
    wr(8'h10, 32'h3000);
    tc(16'h3100, 1'b1);
    chk({31'h0, crit_out}, 32'h1);
    tc(16'h2100, 1'b1);
    chk({31'h0, crit_out}, 32'h0);
    wr(8'h00, 32'h3);
    cka(1'b1);
    chk({31'h0, sd}, 32'h1);
    stop_test;
  end
endmodule : temperature_limit_alarm_test
bind tlalrm_core tlalrm_checker i_chk (.hclk, .hresetn, .clk_en, .ahb_req, .hwdata, .conv,
  .alarm_out, .shutdown, .irq);
`default_nettype wire
